// ### dar_pkg.sv
package dar_pkg;
    // Frequencies in 0.01 Hz steps, bus voltage in volts
    localparam logic [15:0] FREQ_120 = 16'h2ee0;
    // Droop gain in 0.1 % steps
    localparam logic [9:0] DROOP_GAIN_MAX = 10'h3e8;
    localparam int DROOP_SCALE = 1000;
    // Filter time constant in 10 ms steps
    localparam int TAU_UNIT_MS = 10;
    localparam logic [6:0] TAU_MAX = 7'h64;
    localparam logic [6:0] TAU_DEF = 7'h1e;
    localparam int FILT_FRAC = 8;
    // Bus voltage threshold
    localparam logic [9:0] BUS_MIN = 10'h12c;
    localparam logic [9:0] BUS_MAX = 10'h320;
    localparam logic [9:0] BUS_DEF_LO = 10'h190;
    localparam logic [9:0] BUS_DEF_HI = 10'h30c;
    // Compensation limit in 0.01 Hz steps
    localparam logic [13:0] LIM_MAX = 14'h03e8;
    localparam logic [13:0] LIM_DEF = 14'h0258;
    localparam logic [13:0] LIM_OFF = 14'h270f;
    // Avoidance gains in percent
    localparam logic [7:0] GAIN_MAX = 8'hc8;
    localparam logic [7:0] GAIN_DEF = 8'h64;
    localparam int PCT_SCALE = 100;
    // Compensation fall per tick when bus is below level
    localparam logic [15:0] REGEN_DECAY = 16'h0001;
    // Mode selector codes
    localparam logic [1:0] MODE_ALWAYS = 2'h1;
    localparam logic [1:0] MODE_CONST = 2'h2;
    // Update tick
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC_DEF = TICK_US * (CLK_HZ / 1_000_000);

    typedef enum logic [1:0] {
        DAR_RA_OFF,
        DAR_RA_ALWAYS,
        DAR_RA_CONST
    } dar_mode_t;
endpackage : dar_pkg

// ### dar_filt_if.sv
`timescale 1ns/1ps
interface dar_filt_if #(
    parameter int W = 16
);
    logic tick;
    logic signed [W-1:0] x;
    logic [6:0] tau;
    logic signed [W-1:0] y;

    modport src(output tick, output x, output tau, input y);
    modport flt(input tick, input x, input tau, output y);
endinterface : dar_filt_if

// ### dar_lowpass.sv
`timescale 1ns/1ps
module dar_lowpass
    import dar_pkg::*;
#(
    parameter int W = 16
)
(
    input logic clk,
    input logic reset,
    dar_filt_if.flt f
);
    localparam int AW = W + FILT_FRAC;

    typedef struct packed {
        logic signed [AW-1:0] acc;
    } dar_filt_state_t;

    dar_filt_state_t r;
    dar_filt_state_t n;

    if (W < 4 || W > 32)
    begin : g_bad_w
        $error("dar_lowpass: W must be 4 to 32");
    end

    // First-order lowpass, one step per tick
    always_comb
    begin
        logic signed [AW:0] diff;
        logic [10:0] den;
        logic signed [AW:0] q;
        diff = '0;
        den = '0;
        q = '0;
        n = r;
        diff = (AW + 1)'(f.x) <<< FILT_FRAC;
        diff = diff - (AW + 1)'(r.acc);
        den = {4'h0, f.tau} * 11'(TAU_UNIT_MS);
        if (f.tau == 7'h00)
        begin
            n.acc = AW'(f.x) <<< FILT_FRAC;
        end
        else if (f.tick)
        begin
            q = diff / $signed({1'b0, den});
            n.acc = r.acc + $signed(q[AW-1:0]);
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            r <= '0;
        else
            r <= n;
    end

    assign f.y = r.acc[AW-1:FILT_FRAC];

    a_filt_bypass: assert property (@(posedge clk) disable iff (reset)
        (f.tau == 7'h00) |=> (f.y == $past(f.x)))
        else $error("Filter bypass did not pass the sample");
endmodule : dar_lowpass

// ### dar_comp.sv
`timescale 1ns/1ps
module dar_comp
    import dar_pkg::*;
#(
    parameter int FREQ_W = 16,
    parameter int IQ_W = 16,
    parameter int TICK_CYCLES = TICK_CYC_DEF
)
(
    input logic clk,
    input logic reset,
    input logic vector_mode,
    input logic pid_active,
    input logic accel,
    input logic decel,
    input logic const_speed,
    input logic high_voltage_class,
    input logic [9:0] droop_gain_setting,
    input logic [6:0] torque_current_filter_time,
    input logic signed [IQ_W-1:0] torque_current,
    input logic [IQ_W-1:0] rated_torque_current,
    input logic [FREQ_W-1:0] rated_motor_frequency,
    input logic [FREQ_W-1:0] cmd_frequency,
    input logic [FREQ_W-1:0] max_output_frequency,
    input logic [1:0] regen_avoid_mode_select,
    input logic [9:0] regen_avoid_bus_level,
    input logic [9:0] bus_voltage,
    input logic [13:0] regen_avoid_freq_limit,
    input logic [7:0] regen_avoid_voltage_gain,
    input logic [7:0] regen_avoid_freq_gain,
    output logic [FREQ_W-1:0] out_frequency,
    output logic [FREQ_W-1:0] droop_comp_frequency,
    output logic [FREQ_W-1:0] regen_comp_frequency,
    output logic droop_active,
    output logic overload_stall_signal,
    output logic overvoltage_stall_ind,
    output logic stall_prevention_act
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [FREQ_W-1:0] F120 = FREQ_W'(FREQ_120);

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic droop_on;
        logic [FREQ_W-1:0] droop_comp;
        logic [FREQ_W-1:0] regen_comp;
        logic hold;
        logic done;
        logic acting;
        logic [FREQ_W-1:0] out_freq;
    } dar_state_t;

    if (FREQ_W < 14 || FREQ_W > 24)
    begin : g_bad_fw
        $error("dar_comp: FREQ_W must be 14 to 24");
    end
    if (IQ_W < 4 || IQ_W > 24)
    begin : g_bad_iw
        $error("dar_comp: IQ_W must be 4 to 24");
    end
    if (TICK_CYCLES < 1)
    begin : g_bad_tick
        $error("dar_comp: TICK_CYCLES must be at least 1");
    end

    function automatic logic [FREQ_W-1:0] umin(
        input logic [FREQ_W-1:0] a,
        input logic [FREQ_W-1:0] b
    );
        return (a < b) ? a : b;
    endfunction : umin

    function automatic logic [7:0] gain_fix(input logic [7:0] g);
        return (g > GAIN_MAX) ? GAIN_DEF : g;
    endfunction : gain_fix

    function automatic dar_mode_t mode_dec(input logic [1:0] m);
        case (m)
            MODE_ALWAYS: return DAR_RA_ALWAYS;
            MODE_CONST: return DAR_RA_CONST;
            default: return DAR_RA_OFF;
        endcase
    endfunction : mode_dec

    dar_state_t r;
    dar_state_t n;

    logic [6:0] tau_eff;
    logic [9:0] gain_eff;
    logic [IQ_W-1:0] iq_abs;
    dar_mode_t mode;
    logic ra_en;
    logic [9:0] lvl;
    logic over;
    logic [13:0] lim;
    logic lim_on;
    logic [FREQ_W-1:0] limf;
    logic [7:0] vg;
    logic [7:0] fg;

    dar_filt_if #(.W(IQ_W)) filt ();

    // Torque current lowpass
    assign tau_eff = (torque_current_filter_time > TAU_MAX) ? TAU_DEF
                   : torque_current_filter_time;
    assign filt.tick = r.tick;
    assign filt.x = torque_current;
    assign filt.tau = tau_eff;

    dar_lowpass #(.W(IQ_W)) u_filt (
        .clk(clk),
        .reset(reset),
        .f(filt.flt)
    );

    assign iq_abs = filt.y[IQ_W-1] ? IQ_W'(-filt.y) : filt.y;
    assign gain_eff = (droop_gain_setting > DROOP_GAIN_MAX) ? DROOP_GAIN_MAX
                    : droop_gain_setting;

    // Avoidance settings
    assign mode = mode_dec(regen_avoid_mode_select);
    assign ra_en = (mode == DAR_RA_ALWAYS)
                || ((mode == DAR_RA_CONST) && const_speed);
    assign lvl = (regen_avoid_bus_level < BUS_MIN || regen_avoid_bus_level > BUS_MAX)
               ? (high_voltage_class ? BUS_DEF_HI : BUS_DEF_LO)
               : regen_avoid_bus_level;
    assign over = (bus_voltage >= lvl);
    assign lim = (regen_avoid_freq_limit == LIM_OFF) ? LIM_OFF
               : (regen_avoid_freq_limit > LIM_MAX) ? LIM_DEF
               : regen_avoid_freq_limit;
    assign lim_on = (lim != LIM_OFF);
    assign limf = FREQ_W'(lim);
    assign vg = gain_fix(regen_avoid_voltage_gain);
    assign fg = gain_fix(regen_avoid_freq_gain);

    always_comb
    begin
        logic [63:0] num;
        logic [63:0] den;
        logic [63:0] quo;
        logic [FREQ_W-1:0] base;
        logic [25:0] prod;
        logic [25:0] step;
        logic [FREQ_W:0] sum;
        logic [FREQ_W-1:0] c;
        logic h;
        logic d;
        num = '0;
        den = '0;
        quo = '0;
        base = '0;
        prod = '0;
        step = '0;
        sum = '0;
        c = '0;
        h = 1'b0;
        d = 1'b0;
        n = r;
        n.tick = 1'b0;

        // Update tick
        if (r.tick_cnt == TW'(TICK_CYCLES - 1))
        begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.tick_cnt = r.tick_cnt + TW'(1);
        end

        // Droop amount scaled to rated frequency
        num = 64'(iq_abs) * 64'(gain_eff) * 64'(rated_motor_frequency);
        den = 64'(rated_torque_current) * 64'(DROOP_SCALE);
        quo = (den == 64'h0) ? 64'h0 : num / den;
        n.droop_on = vector_mode && (gain_eff != 10'h000) && !pid_active;
        if (!n.droop_on)
            n.droop_comp = '0;
        else if (quo > 64'(F120))
            n.droop_comp = F120;
        else
            n.droop_comp = quo[FREQ_W-1:0];

        // Command less droop
        if (r.droop_on)
        begin
            base = (cmd_frequency > r.droop_comp)
                 ? cmd_frequency - r.droop_comp : '0;
            base = umin(base, umin(F120, max_output_frequency));
        end
        else
        begin
            base = cmd_frequency;
        end

        // Avoidance compensation
        prod = 26'(bus_voltage - lvl) * 26'(vg) * 26'(fg);
        step = prod / 26'(PCT_SCALE * PCT_SCALE) + 26'h1;
        sum = '0;
        c = r.regen_comp;
        h = r.hold;
        d = r.done;
        if (r.tick)
        begin
            if (over)
            begin
                if (step > 26'(max_output_frequency))
                begin
                    c = max_output_frequency;
                end
                else
                begin
                    sum = {1'b0, c} + (FREQ_W + 1)'(step);
                    c = (sum > {1'b0, max_output_frequency})
                      ? max_output_frequency : sum[FREQ_W-1:0];
                end
            end
            else
            begin
                c = (c > FREQ_W'(REGEN_DECAY)) ? c - FREQ_W'(REGEN_DECAY) : '0;
            end
        end

        if (!lim_on)
        begin
            h = 1'b0;
            d = 1'b0;
        end
        else if (!decel)
        begin
            h = 1'b0;
            d = 1'b0;
            c = umin(c, limf);
        end
        else if (d)
        begin
            c = umin(c, limf);
        end
        else if (h || c > limf)
        begin
            h = 1'b1;
            c = limf;
            if (r.out_freq <= (limf >> 1))
            begin
                h = 1'b0;
                d = 1'b1;
            end
        end

        if (c == '0)
            d = 1'b0;

        if (!ra_en)
        begin
            c = '0;
            h = 1'b0;
            d = 1'b0;
        end

        n.regen_comp = c;
        n.hold = h;
        n.done = d;
        n.acting = (c != '0);

        // Command plus avoidance, held under maximum
        sum = {1'b0, base} + {1'b0, r.regen_comp};
        n.out_freq = (sum > {1'b0, max_output_frequency})
                   ? max_output_frequency : sum[FREQ_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            r <= '0;
        else
            r <= n;
    end

    assign out_frequency = r.out_freq;
    assign droop_comp_frequency = r.droop_comp;
    assign regen_comp_frequency = r.regen_comp;
    assign droop_active = r.droop_on;
    assign overload_stall_signal = r.acting;
    assign overvoltage_stall_ind = r.acting;
    assign stall_prevention_act = r.acting;

    a_droop_off: assert property (@(posedge clk) disable iff (reset)
        (!vector_mode || pid_active || droop_gain_setting == 10'h000)
        |=> (droop_comp_frequency == '0 && !droop_active))
        else $error("Droop compensation present while disabled");

    a_droop_cap: assert property (@(posedge clk) disable iff (reset)
        droop_comp_frequency <= F120)
        else $error("Droop compensation above 120 Hz");

    a_droop_out_max: assert property (@(posedge clk) disable iff (reset)
        (r.droop_on && r.regen_comp == '0) |=> (out_frequency <= F120))
        else $error("Drooped frequency above 120 Hz");

    a_regen_mode_off: assert property (@(posedge clk) disable iff (reset)
        !ra_en |=> (regen_comp_frequency == '0 && !overload_stall_signal))
        else $error("Avoidance acting while disabled");

    a_regen_rise: assert property (@(posedge clk) disable iff (reset)
        (ra_en && over && r.tick && !decel && lim_on && r.regen_comp < limf
         && r.regen_comp < max_output_frequency)
        |=> (regen_comp_frequency > $past(regen_comp_frequency)))
        else $error("Avoidance did not raise frequency");

    a_regen_limit: assert property (@(posedge clk) disable iff (reset)
        (ra_en && lim_on && !decel) |=> (regen_comp_frequency <= $past(limf)))
        else $error("Avoidance raise above limit");

    a_regen_hold: assert property (@(posedge clk) disable iff (reset)
        (ra_en && lim_on && decel && r.hold && r.out_freq > (limf >> 1))
        |=> (regen_comp_frequency == $past(limf)))
        else $error("Limit not held during deceleration");

    a_regen_fmax: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> (out_frequency <= $past(max_output_frequency)))
        else $error("Output above maximum frequency");

    a_regen_flag: assert property (@(posedge clk) disable iff (reset)
        (ra_en && over && r.tick && limf != '0 && max_output_frequency != '0)
        |=> overload_stall_signal)
        else $error("Overload signal missing while avoiding");

    a_stall_follow: assert property (@(posedge clk) disable iff (reset)
        (regen_comp_frequency != '0) |-> (stall_prevention_act && overvoltage_stall_ind))
        else $error("Stall prevention not active while avoiding");
endmodule : dar_comp

// ### dar_drive_model.sv
`timescale 1ns/1ps
// Measurement path of the drive: sampled torque current and bus voltage
module dar_drive_model
    import dar_pkg::*;
#(
    parameter int IQ_W = 16
)
(
    input wire logic clk,
    input wire logic signed [IQ_W-1:0] iq_target,
    input wire logic [9:0] bus_target,
    output logic signed [IQ_W-1:0] torque_current,
    output logic [9:0] bus_voltage
);
    // One sample of conversion delay on both measurements
    always_ff @(posedge clk)
    begin
        torque_current <= iq_target;
        bus_voltage <= bus_target;
    end
endmodule : dar_drive_model

// ### tb_droop_and_regen_avoid_comp.sv
`timescale 1ns/1ps
module tb_droop_and_regen_avoid_comp
    import dar_pkg::*;
;
    logic clk, reset, vector_mode, pid_active, accel, decel, const_speed, hvc;
    logic [9:0] gain, level, bus_t, bus;
    logic [6:0] tau;
    logic signed [15:0] iq_t, iq;
    logic [15:0] rated_iq, rated_f, cmd, fmax, out_f, droop_f, regen_f;
    logic [1:0] mode;
    logic [13:0] lim;
    logic [7:0] vg, fg;
    logic droop_act, ovl, ovs, spa;
    int n_errors = 0;
    int checks_done = 0;
    logic [7:0] vgs [4] = '{8'h64, 8'hc8, 8'h64, 8'h00};
    logic [7:0] fgs [4] = '{8'h64, 8'h64, 8'h32, 8'h64};
    logic [15:0] exps [4] = '{16'h000b, 16'h0015, 16'h0006, 16'h0001};

    dar_drive_model PM (.clk(clk), .iq_target(iq_t), .bus_target(bus_t),
        .torque_current(iq), .bus_voltage(bus));

    dar_comp #(.TICK_CYCLES(4)) DUT (.clk(clk), .reset(reset), .vector_mode(vector_mode),
        .pid_active(pid_active), .accel(accel), .decel(decel), .const_speed(const_speed),
        .high_voltage_class(hvc), .droop_gain_setting(gain), .torque_current_filter_time(tau),
        .torque_current(iq), .rated_torque_current(rated_iq), .rated_motor_frequency(rated_f),
        .cmd_frequency(cmd), .max_output_frequency(fmax), .regen_avoid_mode_select(mode),
        .regen_avoid_bus_level(level), .bus_voltage(bus), .regen_avoid_freq_limit(lim),
        .regen_avoid_voltage_gain(vg), .regen_avoid_freq_gain(fg), .out_frequency(out_f),
        .droop_comp_frequency(droop_f), .regen_comp_frequency(regen_f),
        .droop_active(droop_act), .overload_stall_signal(ovl), .overvoltage_stall_ind(ovs),
        .stall_prevention_act(spa));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk_f(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_f

    task automatic chk_b(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_b

    task automatic chk_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checks_done++;
        if ($isunknown(got) || !(got >= lo && got <= hi))
        begin
            n_errors++;
            $display("Error t=%0t got %h exp %h to %h", $time, got, lo, hi);
        end
    endtask : chk_rng

    task automatic close_out();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic wait_regen();
        int i;
        for (i = 0; i < 200 && regen_f === 16'h0000; i++)
            cyc(1);
        if (i == 200)
        begin
            n_errors++;
            $display("Error t=%0t got %h exp %h", $time, regen_f, 16'h0001);
            close_out();
        end
    endtask : wait_regen

    initial
    begin
        reset = 1'b1; vector_mode = 1'b0; pid_active = 1'b0; accel = 1'b0; decel = 1'b0;
        const_speed = 1'b0; hvc = 1'b0; gain = 10'h000; tau = 7'h00; iq_t = 16'sh0000;
        rated_iq = 16'h03e8; rated_f = 16'h1388; cmd = 16'h1770; fmax = 16'h2ee0;
        mode = 2'h0; level = 10'h190; bus_t = 10'h12c; lim = 14'h0258; vg = 8'h64; fg = 8'h64;
        cyc(10);
        reset = 1'b0;
        vector_mode = 1'b1; gain = 10'h3e8; tau = 7'h01; iq_t = 16'sh03e8;
        cyc(14);
        chk_rng(droop_f, 16'h0001, 16'h1387);
        tau = 7'h00;
        cyc(6);
        chk_f(droop_f, 16'h1388);
        chk_f(out_f, 16'h03e8);
        chk_b(droop_act, 1'b1);
        gain = 10'h1f4;
        cyc(4);
        chk_f(droop_f, 16'h09c4);
        chk_f(out_f, 16'h0dac);
        gain = 10'h000;
        cyc(4);
        chk_f(droop_f, 16'h0000);
        chk_b(droop_act, 1'b0);
        chk_f(out_f, 16'h1770);
        gain = 10'h3e8; pid_active = 1'b1;
        cyc(4);
        chk_f(droop_f, 16'h0000);
        pid_active = 1'b0; vector_mode = 1'b0;
        cyc(4);
        chk_f(droop_f, 16'h0000);
        vector_mode = 1'b1; rated_f = 16'h4e20; cmd = 16'h3a98;
        cyc(4);
        chk_f(droop_f, 16'h2ee0);
        chk_f(out_f, 16'h0bb8);
        rated_f = 16'h1388; gain = 10'h064; fmax = 16'h32c8;
        cyc(4);
        chk_f(out_f, 16'h2ee0);
        vector_mode = 1'b0; gain = 10'h000; cmd = 16'h1770; fmax = 16'h2ee0;
        $display("test droop done");
        for (int k = 0; k < 4; k++)
        begin
            mode = 2'h0; vg = vgs[k]; fg = fgs[k]; bus_t = 10'h19a;
            cyc(3);
            mode = 2'h1;
            wait_regen();
            chk_f(regen_f, exps[k]);
            chk_b(ovl, 1'b1);
            chk_b(ovs, 1'b1);
            chk_b(spa, 1'b1);
            cyc(1);
            chk_f(out_f, 16'h1770 + exps[k]);
        end
        $display("test regen gains done");
        bus_t = 10'h1f4; accel = 1'b1;
        vg = 8'hff;
        fg = 8'h64;
        lim = 14'h07d0;
        cyc(60);
        chk_f(regen_f, 16'h0258);
        chk_f(out_f, 16'h19c8);
        accel = 1'b0; decel = 1'b1; lim = 14'h270f;
        cyc(40);
        lim = 14'h0258; bus_t = 10'h0c8;
        cyc(20);
        chk_f(regen_f, 16'h0258);
        decel = 1'b0;
        cyc(8);
        chk_rng(regen_f, 16'h0001, 16'h0257);
        lim = 14'h270f; bus_t = 10'h1f4; fmax = 16'h1a2c;
        cyc(40);
        chk_f(out_f, 16'h1a2c);
        chk_rng(regen_f, 16'h0259, 16'hffff);
        $display("test regen limits done");
        mode = 2'h0;
        cyc(3);
        chk_f(regen_f, 16'h0000);
        chk_b(ovl, 1'b0);
        mode = 2'h3;
        cyc(12);
        chk_f(regen_f, 16'h0000);
        mode = 2'h2;
        cyc(12);
        chk_f(regen_f, 16'h0000);
        const_speed = 1'b1;
        wait_regen();
        chk_b(ovl, 1'b1);
        mode = 2'h0;
        cyc(3);
        level = 10'h064; hvc = 1'b1; bus_t = 10'h2bc; mode = 2'h1;
        cyc(20);
        chk_f(regen_f, 16'h0000);
        bus_t = 10'h316;
        wait_regen();
        chk_f(regen_f, 16'h000b);
        $display("test regen modes done");
        close_out();
    end
endmodule : tb_droop_and_regen_avoid_comp
